// [sim/adcc_control_asserts.sv]
// port-level assertions of the converter control block
`timescale 1ns/1ps
`default_nettype none
module adcc_control_asserts #(
   parameter int ADDR_W   = 10,
   parameter int RESULT_W = 10
) (
   // system and bus
   input wire logic                      mclk,
   input wire logic                      rst,
   input wire logic                      wb_cyc_i,
   input wire logic                      wb_stb_i,
   input wire logic                      wb_we_i,
   input wire logic [ADDR_W-1:0]         wb_adr_i,
   input wire logic [3:0]                wb_sel_i,
   input wire logic [31:0]               wb_dat_i,
   input wire logic [31:0]               wb_dat_o,
   input wire logic                      wb_ack_o,
   // processor side and core
   input wire logic                      globalIrqEnable,
   input wire logic                      irqVectorTaken,
   input wire logic                      convDoneIrq,
   input wire logic [7:1]                triggerFlags,
   input wire logic [RESULT_W-1:0]       coreResult,
   input wire adcc_pkg::adcc_core_ctrl_t coreCtrl
);
   import adcc_pkg::*;
   logic [5:0] tickCount;
   // converter ticks seen in the running conversion
   always_ff @(posedge mclk or posedge rst) begin
      if (rst)
         tickCount <= 6'h00;
      else if (!coreCtrl.converting)
         tickCount <= 6'h00;
      else if (coreCtrl.convClock)
         tickCount <= tickCount + 6'h01;
   end
   default clocking @(posedge mclk); endclocking
   default disable iff (rst);
   sequence s_request;
      wb_cyc_i && wb_stb_i && !wb_ack_o;
   endsequence
   sequence s_ack_pulse;
      wb_ack_o ##1 !wb_ack_o;
   endsequence
   a_ack_one_cycle: assert property (s_request |=> s_ack_pulse)
      else $error("ack not one cycle after request");
   a_temp_sensor: assert property (coreCtrl.powered |->
      coreCtrl.tempSensorOn == (coreCtrl.channel == ADCC_CH_TEMP_SENSOR))
      else $error("sensor power disagrees with channel");
   a_ref_internal: assert property (coreCtrl.powered &&
      coreCtrl.reference == ADCC_REF_INTERNAL |-> coreCtrl.bandgapOn)
      else $error("internal reference without bandgap");
   a_select_frozen: assert property (coreCtrl.converting &&
      $past(coreCtrl.converting) |->
      $stable(coreCtrl.channel) && $stable(coreCtrl.reference))
      else $error("selection changed mid conversion");
   a_off_idle: assert property (!coreCtrl.powered |->
      !coreCtrl.converting)
      else $error("converting while off");
   a_conv_length: assert property ($fell(coreCtrl.converting) &&
      coreCtrl.powered |-> tickCount == 6'd13 || tickCount == 6'd25)
      else $error("conversion length wrong");
   a_irq_vector: assert property (irqVectorTaken &&
      !coreCtrl.converting |-> ##2 !convDoneIrq)
      else $error("request kept after vector taken");
   a_irq_global: assert property (convDoneIrq |->
      $past(globalIrqEnable))
      else $error("request without global enable");
   a_tick_pulse: assert property (coreCtrl.convClock |=>
      !coreCtrl.convClock)
      else $error("converter tick longer than one cycle");
   c_conv_done: cover property ($fell(coreCtrl.converting));
endmodule
bind adcc_control adcc_control_asserts #(.ADDR_W(ADDR_W),
   .RESULT_W(RESULT_W)) i_adcc_control_asserts (.*);
`default_nettype wire

// [sim/adcc_control_bench.sv]
// self-checking bench of the converter control block
`timescale 1ns/1ps
`default_nettype none
module adcc_control_bench;
   import adcc_pkg::*;
   localparam logic [7:0] LO = ADCC_IDX_RESULT_LOW;
   localparam logic [7:0] HI = ADCC_IDX_RESULT_HIGH;
   localparam logic [7:0] CS = ADCC_IDX_CTRL_STATUS;
   localparam logic [7:0] IN = ADCC_IDX_INPUT_REF;
   // ----------------------------------------------------------
   // stimulus, design and partner
   // ----------------------------------------------------------
   logic mclk = 1'b0, rst = 1'b1, wb_cyc_i = 1'b0, wb_stb_i = 1'b0;
   logic wb_we_i = 1'b0, globalIrqEnable = 1'b0, irqVectorTaken = 1'b0;
   logic wb_ack_o, convDoneIrq;
   logic [3:0] wb_sel_i = 4'h0;
   logic [9:0] wb_adr_i = 10'h000, analogLevel = 10'h000, coreResult;
   logic [31:0] wb_dat_i = 32'h0, wb_dat_o;
   logic [7:1] triggerFlags = 7'h00;
   logic [15:0] seed = 16'h0061;
   logic [9:0] lvl, old;
   logic [7:0] rd;
   logic [7:0] roIdx [3] = '{8'h78, 8'h79, 8'h7d};
   adcc_core_ctrl_t coreCtrl;
   int failures = 0, comparisons = 0, t;
   // system clock
   always #2.5 mclk = ~mclk;
   adcc_control i_adcc_control (.*);
   adcc_core_model i_adcc_core_model (.*);
   // ----------------------------------------------------------
   // helpers
   // ----------------------------------------------------------
   function automatic logic [15:0] lfsr(input logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction
   // expected high and low bytes for a result and alignment
   function automatic logic [15:0] present(input logic [9:0] v,
                                           input logic l);
      return l ? {v, 6'h00} : {6'h00, v};
   endfunction
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         failures++;
         $display("Error at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic results();
      $display("comparisons %0d failures %0d", comparisons, failures);
      if (failures == 0 && comparisons > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask
   // one classic bus cycle, read data left in rd
   task automatic bus(input logic [7:0] i, input logic w, input logic [7:0] d);
      int n;
      @(posedge mclk);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i <= w;
      wb_sel_i <= 4'h1;
      wb_adr_i <= {i, 2'b00};
      wb_dat_i <= {24'h0, d};
      n = 0;
      do begin
         @(posedge mclk);
         n++;
      end while (wb_ack_o !== 1'b1 && n < 50);
      if (wb_ack_o !== 1'b1)
         bail();
      rd = wb_dat_o[7:0];
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
   endtask
   task automatic bail();
      failures++;
      results();
   endtask
   // edges up to the next converter tick
   task automatic waitTick(output int n);
      n = 0;
      do begin
         @(posedge mclk);
         n++;
      end while (coreCtrl.convClock !== 1'b1 && n < 300);
      if (n >= 300)
         bail();
   endtask
   // ticks counted over one whole conversion
   task automatic runConv(output int k);
      int n;
      k = 0;
      for (n = 0; coreCtrl.converting !== 1'b1 && n < 10; n++)
         @(posedge mclk);
      do begin
         k += (coreCtrl.convClock & coreCtrl.converting) === 1'b1;
         @(posedge mclk);
         n++;
      end while (coreCtrl.converting === 1'b1 && n < 1000);
      if (n >= 1000)
         bail();
   endtask
   task automatic readPair(input logic l, input logic [9:0] v);
      logic [15:0] e;
      e = present(v, l);
      bus(LO, 1'b0, 8'h00);
      check(rd, e[7:0]);
      bus(HI, 1'b0, 8'h00);
      check(rd, e[15:8]);
   endtask
   // new random level for the next conversion
   task automatic draw();
      seed = lfsr(seed);
      lvl = seed[9:0];
      analogLevel <= lvl;
   endtask
   // ----------------------------------------------------------
   // scenarios
   // ----------------------------------------------------------
   initial begin
      repeat (16) @(posedge mclk);
      rst <= 1'b0;
      for (int i = 8'h78; i <= 8'h7d; i++) begin
         bus(8'(i), 1'b0, 8'h00);
         check(rd, 8'h00);
      end
      foreach (roIdx[i]) begin
         bus(roIdx[i], 1'b1, 8'hff);
         bus(roIdx[i], 1'b0, 8'h00);
         check(rd, 8'h00);
      end
      $display("reset test done");
      bus(CS, 1'b1, 8'h80);
      for (int i = 0; i < 16; i++) begin
         bus(IN, 1'b1, {i[1:0], 2'b00, i[3:0]});
         repeat (2) @(posedge mclk);
         check(coreCtrl.channel, i[3:0]);
         check(coreCtrl.reference, i[1:0]);
         check(coreCtrl.tempSensorOn, i == 8);
         check(coreCtrl.bandgapOn, i[1:0] == 2'h3 || i == 14);
      end
      for (int c = 0; c < 8; c++) begin
         bus(CS, 1'b1, 8'h80 | 8'(c));
         repeat (2) waitTick(t);
         waitTick(t);
         check(t, (c == 0) ? 2 : (1 << c));
      end
      $display("select and divider test done");
      bus(CS, 1'b1, 8'h00);
      bus(IN, 1'b1, 8'hc8);
      draw();
      bus(CS, 1'b1, 8'hc0);
      runConv(t);
      check(t, 25);
      bus(CS, 1'b0, 8'h00);
      check(rd & 8'h50, 8'h10);
      readPair(1'b0, lvl);
      bus(IN, 1'b1, 8'he8);
      readPair(1'b1, lvl);
      bus(LO, 1'b0, 8'h00);
      old = lvl;
      draw();
      bus(CS, 1'b1, 8'hd0);
      runConv(t);
      check(t, 13);
      bus(HI, 1'b0, 8'h00);
      readPair(1'b1, old);
      check(coreCtrl.converting, 1'b0);
      bus(CS, 1'b1, 8'hc0);
      bus(CS, 1'b0, 8'h00);
      check(rd[6], 1'b1);
      bus(IN, 1'b1, 8'hc3);
      check(coreCtrl.channel, 4'h8);
      readPair(1'b0, old);
      bus(CS, 1'b1, 8'h00);
      bus(CS, 1'b0, 8'h00);
      check(rd, 8'h10);
      $display("conversion test done");
      globalIrqEnable <= 1'b1;
      draw();
      bus(CS, 1'b1, 8'hd8);
      runConv(t);
      check(t, 25);
      repeat (2) @(posedge mclk);
      check(convDoneIrq, 1'b1);
      irqVectorTaken <= 1'b1;
      @(posedge mclk);
      irqVectorTaken <= 1'b0;
      repeat (2) @(posedge mclk);
      check(convDoneIrq, 1'b0);
      readPair(1'b0, lvl);
      bus(CS, 1'b1, 8'hd0);
      runConv(t);
      bus(CS, 1'b1, 8'h80);
      bus(CS, 1'b0, 8'h00);
      check(rd, 8'h90);
      bus(CS, 1'b1, 8'h90);
      bus(CS, 1'b0, 8'h00);
      check(rd, 8'h80);
      bus(ADCC_IDX_TRIG_SOURCE, 1'b1, 8'h01);
      bus(CS, 1'b1, 8'ha0);
      triggerFlags <= 7'h01;
      runConv(t);
      check(t, 13);
      bus(ADCC_IDX_TRIG_SOURCE, 1'b1, 8'h00);
      repeat (20) @(posedge mclk);
      check(coreCtrl.converting, 1'b0);
      triggerFlags <= 7'h00;
      bus(CS, 1'b1, 8'hf0);
      repeat (60) @(posedge mclk);
      bus(CS, 1'b0, 8'h00);
      check(rd & 8'h50, 8'h50);
      $display("interrupt and trigger test done");
      results();
   end
endmodule
`default_nettype wire

// [sim/adcc_core_model.sv]
// behavioural analog core behind the converter control block
`timescale 1ns/1ps
`default_nettype none
module adcc_core_model (
   // system and controls
   input  wire logic                      mclk,
   input  wire adcc_pkg::adcc_core_ctrl_t coreCtrl,
   // applied level and digitised value
   input  wire logic [9:0]                analogLevel,
   output logic      [9:0]                coreResult
);
   import adcc_pkg::*;
   logic [9:0] held = 10'h155;
   // tracks the level while converting, toggling garbage otherwise
   always_ff @(posedge mclk) begin
      held <= coreCtrl.converting ? analogLevel : ~held;
   end
   assign coreResult = held;
endmodule
`default_nettype wire

// [verilog/adcc_control.sv]
// control, register and result logic of the 10-bit converter
`timescale 1ns/1ps
`default_nettype none

module adcc_control #(
   parameter int ADDR_W   = 10,
   parameter int RESULT_W = 10
) (
   // system
   input  wire logic                  mclk,
   input  wire logic                  rst,
   // wishbone slave
   input  wire logic                  wb_cyc_i,
   input  wire logic                  wb_stb_i,
   input  wire logic                  wb_we_i,
   input  wire logic [ADDR_W-1:0]     wb_adr_i,
   input  wire logic [3:0]            wb_sel_i,
   input  wire logic [31:0]           wb_dat_i,
   output logic      [31:0]           wb_dat_o,
   output logic                       wb_ack_o,
   // processor side
   input  wire logic                  globalIrqEnable,
   input  wire logic                  irqVectorTaken,
   output logic                       convDoneIrq,
   // trigger source event flags, index 0 unused
   input  wire logic [7:1]            triggerFlags,
   // analog core
   input  wire logic [RESULT_W-1:0]   coreResult,
   output adcc_pkg::adcc_core_ctrl_t  coreCtrl
);
   import adcc_pkg::*;

   // ----------------------------------------------------------------
   // elaboration checks
   // ----------------------------------------------------------------
   if (ADDR_W < 10 || ADDR_W > 32) begin : g_bad_addr
      $error("adcc_control: ADDR_W must lie in 10..32");
   end
   if (RESULT_W != 10) begin : g_bad_result
      $error("adcc_control: RESULT_W must be 10");
   end

   // ----------------------------------------------------------------
   // state
   // ----------------------------------------------------------------
   adcc_state_t     state;
   logic            enable;
   logic            autoTrig;
   logic            doneFlag;
   logic            doneIe;
   logic [2:0]      divider;
   logic [1:0]      reference;
   logic            leftAlign;
   logic [3:0]      channel;
   logic [2:0]      trigSource;
   logic [1:0]      appliedRef;
   logic [3:0]      appliedCh;
   logic            firstPending;
   logic            convLong;
   logic [4:0]      convCnt;
   logic [6:0]      preCnt;
   logic            tick;
   logic            trigPrev;
   logic            resultLock;
   logic [9:0]      result;

   // ----------------------------------------------------------------
   // bus decode
   // ----------------------------------------------------------------
   logic       req;
   logic       wrEn;
   logic       rdEn;
   logic [7:0] idx;
   logic [7:0] wdata;
   logic       wrCsr;
   logic       wrMux;
   logic       wrTrig;
   logic       rdLow;
   logic       rdHigh;

   // request taken at the edge where ack rises
   assign req    = wb_cyc_i & wb_stb_i & ~wb_ack_o;
   assign idx    = wb_adr_i[9:2];
   assign wdata  = wb_dat_i[7:0];
   assign wrEn   = req & wb_we_i & wb_sel_i[0];
   assign rdEn   = req & ~wb_we_i;
   assign wrCsr  = wrEn & (idx == ADCC_IDX_CTRL_STATUS);
   assign wrMux  = wrEn & (idx == ADCC_IDX_INPUT_REF);
   assign wrTrig = wrEn & (idx == ADCC_IDX_TRIG_SOURCE);
   assign rdLow  = rdEn & (idx == ADCC_IDX_RESULT_LOW);
   assign rdHigh = rdEn & (idx == ADCC_IDX_RESULT_HIGH);

   // ----------------------------------------------------------------
   // functions
   // ----------------------------------------------------------------
   // divide mask for the prescaler code
   function automatic logic [6:0] div_mask(input logic [2:0] code);
      logic [6:0] m;
      m = 7'h01;
      if (code > 3'h1) begin
         m = 7'((8'h01 << code) - 8'h01); // code n divides by 2**n
      end
      return m;
   endfunction

   // presented byte of the result for low or high register
   function automatic logic [7:0] result_byte(input logic [9:0] r,
                                              input logic       left,
                                              input logic       high);
      logic [7:0] b;
      b = 8'h00;
      if (left && high) begin
         b = r[9:2];
      end else if (left) begin
         b = {r[1:0], 6'h00};
      end else if (high) begin
         b = {6'h00, r[9:8]};
      end else begin
         b = r[7:0];
      end
      return b;
   endfunction

   // ----------------------------------------------------------------
   // start sources and completion
   // ----------------------------------------------------------------
   logic       enableNow;
   logic       swStart;
   logic       trigSel;
   logic       trigEdge;
   logic       convEnd;
   logic       freeRestart;
   logic       startConv;
   logic [4:0] convLen;

   // enable as seen this cycle, including a write in progress
   assign enableNow = wrCsr ? wdata[ADCC_BIT_ENABLE] : enable;
   // only a one written to start counts
   assign swStart = wrCsr & wdata[ADCC_BIT_START];
   // free-run code selects nothing, so switching to it cannot trigger
   assign trigSel = (trigSource == ADCC_TRIG_FREE_RUN) ? 1'b0
                    : triggerFlags[trigSource];
   assign trigEdge = autoTrig & trigSel & ~trigPrev;
   assign convLen  = convLong ? ADCC_CONV_CYCLES_FIRST
                              : ADCC_CONV_CYCLES_NORMAL;
   assign convEnd  = (state == ADCC_CONVERTING) & tick
                     & (convCnt == convLen - 5'd1);
   assign freeRestart = convEnd & autoTrig
                        & (trigSource == ADCC_TRIG_FREE_RUN);
   assign startConv = enableNow & (state == ADCC_IDLE)
                      & (swStart | trigEdge);

   // ----------------------------------------------------------------
   // wishbone answer, one cycle after the strobe
   // ----------------------------------------------------------------
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         wb_ack_o <= 1'b0;
      end else begin
         wb_ack_o <= req;
      end
   end

   // read data, captured with the ack
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         wb_dat_o <= 32'h0000_0000;
      end else if (rdEn) begin
         unique case (idx)
            ADCC_IDX_RESULT_LOW:
               wb_dat_o <= {24'h00_0000,
                            result_byte(result, leftAlign, 1'b0)};
            ADCC_IDX_RESULT_HIGH:
               wb_dat_o <= {24'h00_0000,
                            result_byte(result, leftAlign, 1'b1)};
            ADCC_IDX_CTRL_STATUS:
               wb_dat_o <= {24'h00_0000, enable,
                            state == ADCC_CONVERTING,
                            autoTrig, doneFlag, doneIe, divider};
            ADCC_IDX_TRIG_SOURCE:
               wb_dat_o <= {29'h0000_0000, trigSource};
            ADCC_IDX_INPUT_REF:
               wb_dat_o <= {24'h00_0000, reference, leftAlign,
                            1'b0, channel};
            default:
               wb_dat_o <= 32'h0000_0000;
         endcase
      end
   end

   // ----------------------------------------------------------------
   // software settings
   // ----------------------------------------------------------------
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         enable   <= ADCC_RST_CTRL_STATUS[ADCC_BIT_ENABLE];
         autoTrig <= ADCC_RST_CTRL_STATUS[ADCC_BIT_AUTO_TRIG];
         doneIe   <= ADCC_RST_CTRL_STATUS[ADCC_BIT_DONE_IE];
         divider  <= ADCC_RST_CTRL_STATUS[ADCC_POS_DIVIDER +: 3];
      end else if (wrCsr) begin
         enable   <= wdata[ADCC_BIT_ENABLE];
         autoTrig <= wdata[ADCC_BIT_AUTO_TRIG];
         doneIe   <= wdata[ADCC_BIT_DONE_IE];
         divider  <= wdata[ADCC_POS_DIVIDER +: 3];
      end
   end

   // input and reference selection as written
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         reference <= ADCC_RST_INPUT_REF[ADCC_POS_REFERENCE +: 2];
         leftAlign <= ADCC_RST_INPUT_REF[ADCC_BIT_LEFT_ALIGN];
         channel   <= ADCC_RST_INPUT_REF[ADCC_POS_CHANNEL +: 4];
      end else if (wrMux) begin
         reference <= wdata[ADCC_POS_REFERENCE +: 2];
         leftAlign <= wdata[ADCC_BIT_LEFT_ALIGN];
         channel   <= wdata[ADCC_POS_CHANNEL +: 4];
      end
   end

   // trigger source selection
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         trigSource <= ADCC_RST_TRIG_SOURCE;
      end else if (wrTrig) begin
         trigSource <= wdata[2:0];
      end
   end

   // applied selection follows the written one only while idle
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         appliedRef <= ADCC_RST_INPUT_REF[ADCC_POS_REFERENCE +: 2];
         appliedCh  <= ADCC_RST_INPUT_REF[ADCC_POS_CHANNEL +: 4];
      end else if (state == ADCC_IDLE) begin
         appliedRef <= reference;
         appliedCh  <= channel;
      end
   end

   // ----------------------------------------------------------------
   // prescaler, runs only while enabled
   // ----------------------------------------------------------------
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         preCnt <= 7'h00;
         tick   <= 1'b0;
      end else if (!enable) begin
         preCnt <= 7'h00;
         tick   <= 1'b0;
      end else begin
         preCnt <= preCnt + 7'h01;
         tick   <= ((preCnt & div_mask(divider))
                    == div_mask(divider));
      end
   end

   // ----------------------------------------------------------------
   // conversion sequencing
   // ----------------------------------------------------------------
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         state    <= ADCC_IDLE;
         convCnt  <= 5'h00;
         convLong <= 1'b0;
      end else if (!enableNow) begin
         state    <= ADCC_IDLE;
         convCnt  <= 5'h00;
      end else begin
         unique case (state)
            ADCC_IDLE: begin
               if (startConv) begin
                  state    <= ADCC_CONVERTING;
                  convCnt  <= 5'h00;
                  convLong <= firstPending | ~enable;
               end
            end
            ADCC_CONVERTING: begin
               if (convEnd && freeRestart) begin
                  convCnt  <= 5'h00;
                  convLong <= 1'b0;
               end else if (convEnd) begin
                  state    <= ADCC_IDLE;
                  convCnt  <= 5'h00;
               end else if (tick) begin
                  convCnt  <= convCnt + 5'h01;
               end
            end
         endcase
      end
   end

   // first conversion after power-up of the converter is the long one
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         firstPending <= 1'b1;
      end else if (!enable) begin
         firstPending <= 1'b1;
      end else if (state == ADCC_CONVERTING) begin
         firstPending <= 1'b0;
      end
   end

   // previous selected trigger level for edge detection
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         trigPrev <= 1'b0;
      end else begin
         trigPrev <= trigSel;
      end
   end

   // ----------------------------------------------------------------
   // result register and read lock
   // ----------------------------------------------------------------
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         resultLock <= 1'b0;
      end else if (rdHigh) begin
         resultLock <= 1'b0;
      end else if (rdLow) begin
         resultLock <= 1'b1;
      end
   end

   // result latched with the flag; held while locked
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         result <= ADCC_RST_RESULT;
      end else if (convEnd && !resultLock) begin
         result <= coreResult;
      end
   end

   // done flag: set wins over both clears
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         doneFlag <= ADCC_RST_CTRL_STATUS[ADCC_BIT_DONE_FLAG];
      end else if (convEnd) begin
         doneFlag <= 1'b1;
      end else if (irqVectorTaken ||
                   (wrCsr && wdata[ADCC_BIT_DONE_FLAG])) begin
         doneFlag <= 1'b0;
      end
   end

   // interrupt request
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         convDoneIrq <= 1'b0;
      end else begin
         convDoneIrq <= doneFlag & doneIe & globalIrqEnable;
      end
   end

   // ----------------------------------------------------------------
   // analog core controls
   // ----------------------------------------------------------------
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         coreCtrl <= '0;
      end else begin
         coreCtrl.powered      <= enable;
         coreCtrl.channel      <= appliedCh;
         coreCtrl.reference    <= appliedRef;
         coreCtrl.tempSensorOn <= enable
                                  & (appliedCh == ADCC_CH_TEMP_SENSOR);
         coreCtrl.bandgapOn    <= enable
                                  & ((appliedRef == ADCC_REF_INTERNAL)
                                     | (appliedCh == ADCC_CH_BANDGAP));
         coreCtrl.convClock    <= tick;
         coreCtrl.converting   <= (state == ADCC_CONVERTING);
      end
   end

endmodule

`default_nettype wire

// [verilog/adcc_pkg.sv]
// constants, types and register map of the converter control block
package adcc_pkg;

   // ----------------------------------------------------------------
   // register indices (byte address = 4 * index)
   // ----------------------------------------------------------------
   localparam logic [7:0] ADCC_IDX_RESULT_LOW  = 8'h78;
   localparam logic [7:0] ADCC_IDX_RESULT_HIGH = 8'h79;
   localparam logic [7:0] ADCC_IDX_CTRL_STATUS = 8'h7a;
   localparam logic [7:0] ADCC_IDX_TRIG_SOURCE = 8'h7b;
   localparam logic [7:0] ADCC_IDX_INPUT_REF   = 8'h7c;

   // ----------------------------------------------------------------
   // reset values
   // ----------------------------------------------------------------
   localparam logic [7:0] ADCC_RST_CTRL_STATUS = 8'h00;
   localparam logic [7:0] ADCC_RST_INPUT_REF   = 8'h00;
   localparam logic [2:0] ADCC_RST_TRIG_SOURCE = 3'h0;
   localparam logic [9:0] ADCC_RST_RESULT      = 10'h000;

   // ----------------------------------------------------------------
   // field positions, control/status register
   // ----------------------------------------------------------------
   localparam int ADCC_BIT_ENABLE     = 7;
   localparam int ADCC_BIT_START      = 6;
   localparam int ADCC_BIT_AUTO_TRIG  = 5;
   localparam int ADCC_BIT_DONE_FLAG  = 4;
   localparam int ADCC_BIT_DONE_IE    = 3;
   localparam int ADCC_POS_DIVIDER    = 0;

   // ----------------------------------------------------------------
   // field positions, input and reference select register
   // ----------------------------------------------------------------
   localparam int ADCC_POS_REFERENCE  = 6;
   localparam int ADCC_BIT_LEFT_ALIGN = 5;
   localparam int ADCC_POS_CHANNEL    = 0;

   // ----------------------------------------------------------------
   // codes
   // ----------------------------------------------------------------
   localparam logic [3:0] ADCC_CH_TEMP_SENSOR = 4'h8;
   localparam logic [3:0] ADCC_CH_BANDGAP     = 4'he;
   localparam logic [3:0] ADCC_CH_GROUND      = 4'hf;
   localparam logic [1:0] ADCC_REF_EXT_PIN    = 2'h0;
   localparam logic [1:0] ADCC_REF_SUPPLY     = 2'h1;
   localparam logic [1:0] ADCC_REF_INTERNAL   = 2'h3;
   localparam logic [2:0] ADCC_TRIG_FREE_RUN  = 3'h0;

   // ----------------------------------------------------------------
   // timing in converter clock cycles
   // ----------------------------------------------------------------
   localparam logic [4:0] ADCC_CONV_CYCLES_NORMAL = 5'd13;
   localparam logic [4:0] ADCC_CONV_CYCLES_FIRST  = 5'd25;

   // conversion state, gray along idle -> converting
   typedef enum logic [0:0] {
      ADCC_IDLE       = 1'b0,
      ADCC_CONVERTING = 1'b1
   } adcc_state_t;

   // controls handed to the analog core
   typedef struct packed {
      logic       powered;      // converter powered
      logic [3:0] channel;      // applied channel code
      logic [1:0] reference;    // applied reference code
      logic       tempSensorOn; // temperature sensor powered
      logic       bandgapOn;    // internal bandgap needed
      logic       convClock;    // one-cycle converter clock tick
      logic       converting;   // conversion in progress
   } adcc_core_ctrl_t;

endpackage
